// ==== logic/byte_port_map.vh ====
// constants for the parallel byte fifo port
`ifndef BYTE_PORT_MAP_VH
`define BYTE_PORT_MAP_VH
`define LANE_WIDTH      8
`define FIFO_DEPTH      16
`define FIFO_ADDR_BITS  4
`define SYNC_STAGES     2
`define STROBE_IDLE     1'b1
`define LANE_RESET      8'h00
`endif

// ==== logic/byte_fifo.v ====
// parameterised valid/ready fifo
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             core_clk_in,
  input  wire             sys_rst_in,
  input  wire             clk_en_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output wire             out_valid_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_ptr;
  reg [AW:0]      rd_ptr;
  wire            full;
  wire            empty;
  wire            push;
  wire            pop;
  assign empty = (wr_ptr == rd_ptr);
  assign full  = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem[rd_ptr[AW-1:0]];
  assign push = in_valid_in & ~full & clk_en_in;
  assign pop  = out_ready_in & ~empty & clk_en_in;
  always @(posedge core_clk_in) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_in;
    end
  end
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= {(AW+1){1'b0}};
      rd_ptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end
endmodule // byte_fifo

// ==== logic/parallel_byte_fifo_port.v ====
// parallel byte fifo port: host strobes into tx buffer, out of rx buffer
//////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`include "byte_port_map.vh"
module parallel_byte_fifo_port (
  input  wire                   core_clk_in,
  input  wire                   sys_rst_in,
  input  wire                   clk_en_in,
  input  wire                   sync_mode_in,
  input  wire [`LANE_WIDTH-1:0] byte_lane_bits_in,
  output reg  [`LANE_WIDTH-1:0] byte_lane_bits_out,
  output wire                   byte_lane_bits_oe_out,
  input  wire                   wr_strobe_n_in,
  input  wire                   rd_strobe_n_in,
  input  wire                   out_en_n_in,
  input  wire                   port_clk_in,
  output wire                   tx_space_n_out,
  output wire                   rx_avail_n_out,
  output wire [`LANE_WIDTH-1:0] tx_data_out,
  output wire                   tx_valid_out,
  input  wire                   tx_ready_in,
  input  wire [`LANE_WIDTH-1:0] rx_data_in,
  input  wire                   rx_valid_in,
  output wire                   rx_ready_out
);
  //////////////////////////////////////////////////////////////////////
  // strobe synchronisers
  reg  [`SYNC_STAGES-1:0] wr_sync;
  reg  [`SYNC_STAGES-1:0] rd_sync;
  reg                     wr_prev;
  reg                     rd_prev;
  wire                    wr_fall;
  wire                    rd_fall;
  wire                    wr_level;
  wire                    rd_level;
  wire                    tx_in_ready;
  wire                    rx_out_valid;
  wire [`LANE_WIDTH-1:0]  rx_head;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_sync <= {`SYNC_STAGES{`STROBE_IDLE}};
      rd_sync <= {`SYNC_STAGES{`STROBE_IDLE}};
      wr_prev <= `STROBE_IDLE;
      rd_prev <= `STROBE_IDLE;
    end else if (clk_en_in) begin
      wr_sync <= {wr_sync[0], wr_strobe_n_in};
      rd_sync <= {rd_sync[0], rd_strobe_n_in};
      wr_prev <= wr_sync[`SYNC_STAGES-1];
      rd_prev <= rd_sync[`SYNC_STAGES-1];
    end
  end
  assign wr_level = wr_sync[`SYNC_STAGES-1];
  assign rd_level = rd_sync[`SYNC_STAGES-1];
  assign wr_fall  = wr_prev & ~wr_level;
  assign rd_fall  = rd_prev & ~rd_level;
  //////////////////////////////////////////////////////////////////////
  // transmit path: host to device
  reg [`LANE_WIDTH-1:0] lane_q;
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lane_q <= `LANE_RESET;
    end else if (clk_en_in) begin
      lane_q <= byte_lane_bits_in; // registered once, one stage ahead of the two-stage synced strobe
    end
  end
  byte_fifo #(.WIDTH(`LANE_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_ADDR_BITS)) tx_buf (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .in_data_in    (lane_q),
    .in_valid_in   (wr_fall),
    .in_ready_out  (tx_in_ready),
    .out_data_out  (tx_data_out),
    .out_valid_out (tx_valid_out),
    .out_ready_in  (tx_ready_in)
  );
  assign tx_space_n_out = ~tx_in_ready;
  //////////////////////////////////////////////////////////////////////
  // receive path: device to host
  byte_fifo #(.WIDTH(`LANE_WIDTH), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_ADDR_BITS)) rx_buf (
    .core_clk_in   (core_clk_in),
    .sys_rst_in    (sys_rst_in),
    .clk_en_in     (clk_en_in),
    .in_data_in    (rx_data_in),
    .in_valid_in   (rx_valid_in),
    .in_ready_out  (rx_ready_out),
    .out_data_out  (rx_head),
    .out_valid_out (rx_out_valid),
    .out_ready_in  (rd_fall)
  );
  assign rx_avail_n_out = ~rx_out_valid;
  // present byte latched at strobe fall, held while strobe low
  always @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      byte_lane_bits_out <= `LANE_RESET;
    end else if (clk_en_in && rd_fall) begin
      byte_lane_bits_out <= rx_head;
    end
  end
  // output enable gates the lane only in synchronous mode
  assign byte_lane_bits_oe_out = ~rd_level & ~rd_prev & (~sync_mode_in | ~out_en_n_in);
  // port clock unused: strobe-paced only
  wire unused_port_clk = port_clk_in;
endmodule // parallel_byte_fifo_port

// ==== bench/host_model.sv ====
// host side strobe model for the byte port
`timescale 1ns/1ps
module host_model (
  input  wire       clk_in,
  input  wire       space_n_in,
  input  wire       avail_n_in,
  input  wire [7:0] lane_in,
  output reg        wr_n_out,
  output reg        rd_n_out,
  output reg  [7:0] data_out,
  output reg  [7:0] got_out
);
  initial begin
    wr_n_out = 1'b1; rd_n_out = 1'b1; data_out = 8'h00; got_out = 8'h00;
  end
  task cyc(input integer n); repeat (n) @(posedge clk_in); #1; endtask
  task wr(input [7:0] b);
    if (!space_n_in) begin
      data_out = b; wr_n_out = 1'b0; cyc(4); wr_n_out = 1'b1; cyc(2); data_out = ~b; cyc(2);
    end
  endtask
  task rd;
    if (!avail_n_in) begin
      rd_n_out = 1'b0; cyc(6); got_out = lane_in; rd_n_out = 1'b1; cyc(4);
    end
  endtask
endmodule // host_model

// ==== bench/parallel_byte_fifo_port_assertions.sv ====
// checker for the parallel byte fifo port
`timescale 1ns/1ps
module byte_port_checker (
  input logic core_clk_in,
  input logic sys_rst_in,
  input logic sync_mode_in,
  input logic out_en_n_in,
  input logic wr_strobe_n_in,
  input logic rd_strobe_n_in,
  input logic byte_lane_bits_oe_out,
  input logic tx_space_n_out,
  input logic rx_avail_n_out,
  input logic tx_valid_out,
  input logic rx_valid_in,
  input logic rx_ready_out
);
  wire oe = byte_lane_bits_oe_out;
  wire rd = rd_strobe_n_in;
  wire wr = wr_strobe_n_in;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_rd_drives_lane: assert property ($fell(rd) && !rx_avail_n_out && !sync_mode_in |-> ##[3:5] oe)
    else $error("lane not driven");
  a_lane_released: assert property (rd && $past(rd, 3) |-> !oe) else $error("lane still driven");
  a_oe_sync_gate: assert property (sync_mode_in && out_en_n_in && $past(out_en_n_in) |-> !oe)
    else $error("oe ignored");
  a_wr_fills_tx: assert property ($fell(wr) && !tx_valid_out |-> ##[3:5] tx_valid_out) else $error("no tx");
  a_no_wr_no_tx: assert property ((wr && !tx_valid_out)[*5] |=> !tx_valid_out) else $error("stray tx");
  a_full_has_data: assert property (tx_space_n_out |-> tx_valid_out) else $error("bad space flag");
  a_rx_flag_cause: assert property ($fell(rx_avail_n_out) |-> $past(rx_valid_in && rx_ready_out))
    else $error("bad avail flag");
  a_rd_pops_rx: assert property ($rose(rx_avail_n_out) |-> !$past(rd, 2)) else $error("stray pop");
endmodule // byte_port_checker
bind parallel_byte_fifo_port byte_port_checker i_chk (.*);

// ==== bench/test_parallel_byte_fifo_port.sv ====
// self-checking bench for the parallel byte fifo port
`timescale 1ns/1ps
module test_parallel_byte_fifo_port;
  reg        clk = 0, rst = 1, sync = 0, oe_n = 0, tx_rdy = 0, rx_vld = 0;
  reg  [7:0] rx_d = 8'h00;
  reg  [7:0] rows [0:3];
  wire [7:0] hd, lo, txd, got;
  wire       wr_n, rd_n, oe, sp_n, av_n, txv, rxr;
  integer    fails = 0, comparisons = 0, i;
  always #4 clk = ~clk;
  parallel_byte_fifo_port i_dut (.core_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1), .sync_mode_in(sync),
    .byte_lane_bits_in(hd), .byte_lane_bits_out(lo), .byte_lane_bits_oe_out(oe), .wr_strobe_n_in(wr_n),
    .rd_strobe_n_in(rd_n), .out_en_n_in(oe_n), .port_clk_in(1'b0), .tx_space_n_out(sp_n), .rx_avail_n_out(av_n),
    .tx_data_out(txd), .tx_valid_out(txv), .tx_ready_in(tx_rdy), .rx_data_in(rx_d), .rx_valid_in(rx_vld),
    .rx_ready_out(rxr));
  host_model i_host (.clk_in(clk), .space_n_in(sp_n), .avail_n_in(av_n), .lane_in(oe ? lo : ~hd),
    .wr_n_out(wr_n), .rd_n_out(rd_n), .data_out(hd), .got_out(got));
  task check(input [8:0] a, input [8:0] e);
    comparisons = comparisons + 1;
    if (a !== e) begin
      fails = fails + 1; $display("wrong value at %0t: got %h want %h", $time, a, e);
    end
  endtask
  task push(input [7:0] b);
    rx_d = b;
    rx_vld = 1;
    @(posedge clk); #1;
    rx_vld = 0;
    @(posedge clk); #1;
  endtask
  task pop;
    tx_rdy = 1;
    @(posedge clk); #1;
    tx_rdy = 0;
    @(posedge clk); #1;
  endtask
  task give_verdict;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin #30000; fails = fails + 1; give_verdict; end
  initial begin
    rows[0] = 8'h00; rows[1] = 8'hff; rows[2] = 8'h5a; rows[3] = 8'ha5;
    repeat (20) @(posedge clk); #1; rst = 0;
    check({5'h00, rxr, sp_n, av_n, oe}, 9'h00a);
    for (i = 0; i < 4; i = i + 1) i_host.wr(rows[i]);
    for (i = 0; i < 4; i = i + 1) begin
      check({txv, txd}, {1'b1, rows[i]}); pop;
    end
    for (i = 0; i < 4; i = i + 1) push(rows[i]);
    for (i = 0; i < 4; i = i + 1) begin
      i_host.rd; check({1'b0, got}, {1'b0, rows[i]});
    end
    check({8'h00, av_n}, 9'h001);
    $display("test rows done");
    for (i = 0; i < 16; i = i + 1) i_host.wr(i[7:0]);
    check({8'h00, sp_n}, 9'h001);
    i_host.wr(8'h77);
    for (i = 0; i < 16; i = i + 1) begin
      check({txv, txd}, {1'b1, i[7:0]}); pop;
    end
    check({8'h00, txv}, 9'h000);
    $display("test full done");
    sync = 1; push(8'hc3); i_host.rd;
    check({1'b0, got}, 9'h0c3);
    oe_n = 1; push(8'h3c); i_host.rd;
    check({1'b0, got}, {1'b0, ~hd});
    check({8'h00, av_n}, 9'h001);
    $display("test sync done");
    give_verdict;
  end
endmodule // test_parallel_byte_fifo_port
